/* src/nlk_pkg.sv */
package nlk_pkg;

	// lock field codes, ordered from open to closed
	localparam logic [1:0] UNLOCKED_CODE      = 2'h3;
	localparam logic [1:0] WRITE_PROTECT_CODE = 2'h2;
	localparam logic [1:0] READ_PROTECT_CODE  = 2'h1;
	localparam logic [1:0] FULL_PROTECT_CODE  = 2'h0;
	localparam logic [1:0] PROG_UNLOCKED_CODE = 2'h3;

	// lock byte layout: field index i occupies bits 2*i+1:2*i
	localparam int        FIELD_W       = 2;
	localparam int        NUM_FIELDS    = 4;
	localparam int        PROG_FIELD    = 0;
	localparam int        TABLE_FIELD   = 1;
	localparam int        APP_FIELD     = 2;
	localparam int        BOOT_FIELD    = 3;
	localparam logic [7:0] LOCK_RESET   = 8'hff;

	// register map, byte addresses on the bus
	localparam int        ADR_W         = 8;
	localparam logic [7:0] ADDR_LOCK    = 8'h00;
	localparam logic [7:0] ADDR_CTRL    = 8'h04;
	localparam logic [7:0] ADDR_STAT    = 8'h08;

	// control register bits
	localparam int        CTRL_ERASE_BIT    = 0;
	localparam int        CTRL_VEC_BOOT_BIT = 1;

	// status register bits, write one to clear
	localparam int        STAT_W             = 5;
	localparam int        STAT_STORE_BLOCKED = 0;
	localparam int        STAT_LOAD_BLOCKED  = 1;
	localparam int        STAT_PROG_REFUSED  = 2;
	localparam int        STAT_WR_REJECTED   = 3;
	localparam int        STAT_ERASE_DONE    = 4;
	localparam logic [4:0] STAT_RESET        = 5'h00;

	typedef enum logic [1:0] {
		NLK_SEC_APP   = 2'h0,
		NLK_SEC_TABLE = 2'h1,
		NLK_SEC_BOOT  = 2'h2,
		NLK_SEC_NONE  = 2'h3
	} nlk_section_t;

	typedef enum logic [2:0] {
		NLK_OP_READ_MEM   = 3'h0,
		NLK_OP_WRITE_MEM  = 3'h1,
		NLK_OP_READ_FUSE  = 3'h2,
		NLK_OP_WRITE_FUSE = 3'h3,
		NLK_OP_READ_LOCK  = 3'h4,
		NLK_OP_WRITE_LOCK = 3'h5,
		NLK_OP_CHIP_ERASE = 3'h6,
		NLK_OP_IDLE       = 3'h7
	} nlk_prog_op_t;

	typedef enum {NLK_ST_LOAD, NLK_ST_RUN} nlk_state_t;

	typedef struct packed {
		logic         valid;
		logic         is_store;
		nlk_section_t target;
	} nlk_cpu_req_t;

	typedef struct packed {
		logic done;
		logic allow;
	} nlk_cpu_rsp_t;

	typedef struct packed {
		logic         valid;
		nlk_prog_op_t op;
		logic [7:0]   wdata;
	} nlk_prog_req_t;

	typedef struct packed {
		logic       done;
		logic       grant;
		logic [7:0] rdata;
	} nlk_prog_rsp_t;

endpackage : nlk_pkg

/* src/nlk_lock_field.sv */
`timescale 1ns/1ps
`default_nettype none

module nlk_lock_field (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       load_en,
	input  wire logic [1:0] load_code,
	input  wire logic       erase,
	input  wire logic       wr_en,
	input  wire logic [1:0] wr_code,
	output logic [1:0]      code_ff,
	output logic            reject
);

	// a write may only clear bits: any bit set that is clear now is a relax
	assign reject = wr_en && (|(wr_code & ~code_ff));

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			code_ff <= nlk_pkg::UNLOCKED_CODE;
		end else if (load_en) begin
			code_ff <= load_code;
		end else if (erase) begin
			code_ff <= nlk_pkg::UNLOCKED_CODE;
		end else if (wr_en && !reject) begin
			code_ff <= wr_code;
		end
	end

endmodule : nlk_lock_field

`default_nettype wire

/* src/nlk_lock_enforce.sv */
// Functional notes
// - app field bits 5:4, stricter writes only
// - app field relaxes only on chip erase
// - app code 11: no store/load restriction
// - app code 10: block stores to app
// - app code 01: block boot loads of app
// - app code 00: block stores and boot loads
// - read lock, boot vectors: irq off in app
// - table field bits 3:2, stricter writes only
// - table field relaxes only on chip erase
// - table codes mirror app section restrictions
// - prog field bits 1:0, programmer writes only
// - prog field cleared only by chip erase
// - prog code 11: programmer unrestricted
// - prog code 10: refuse memory, fuse writes
// - prog code 00: refuse all programmer access but chip erase
// - boot field bits 7:6, stricter, erase relaxes
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module nlk_lock_enforce (
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	input  wire logic [7:0]             nvm_lock_image,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic [31:0]                 wb_dat_o,
	output logic                        wb_ack_o,
	input  wire nlk_pkg::nlk_cpu_req_t  cpu_req,
	input  wire logic                   cpu_in_boot,
	output nlk_pkg::nlk_cpu_rsp_t       cpu_rsp,
	output logic                        irq_disable,
	input  wire nlk_pkg::nlk_prog_req_t prog_req,
	output nlk_pkg::nlk_prog_rsp_t      prog_rsp,
	output logic [7:0]                  lock_byte
);

	function automatic logic read_locked(input logic [1:0] code);
		return !code[1];
	endfunction : read_locked

	function automatic logic write_locked(input logic [1:0] code);
		return !code[0];
	endfunction : write_locked

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] reg_adr);
		return adr == reg_adr;
	endfunction : hit

	nlk_pkg::nlk_state_t    state_ff;
	logic                   ack_ff;
	logic [31:0]            dat_ff;
	logic                   vec_boot_ff;
	logic [4:0]             stat_ff;
	nlk_pkg::nlk_cpu_rsp_t  cpu_rsp_ff;
	nlk_pkg::nlk_prog_rsp_t prog_rsp_ff;
	logic                   irq_off_ff;

	logic [1:0] code [nlk_pkg::NUM_FIELDS];
	logic [3:0] fld_reject;
	logic [3:0] fld_wr_en;
	logic [1:0] fld_wr_code [nlk_pkg::NUM_FIELDS];

	logic       wb_req;
	logic       wb_wr;
	logic       wb_wr_lock;
	logic       cpu_erase;
	logic       prog_go;
	logic       prog_refuse;
	logic       prog_wr_lock;
	logic       erase_go;
	logic       load_en;
	logic [1:0] tgt_code;
	logic       cpu_block;
	logic       app_rd_any;

	assign wb_req     = wb_cyc_i && wb_stb_i && !ack_ff;
	// writes land on the edge at which the master sees ack high
	assign wb_wr      = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i
		&& wb_sel_i[0];
	assign wb_wr_lock = wb_wr && hit(wb_adr_i, nlk_pkg::ADDR_LOCK);
	assign cpu_erase  = wb_wr && hit(wb_adr_i, nlk_pkg::ADDR_CTRL)
		&& wb_dat_i[nlk_pkg::CTRL_ERASE_BIT];
	assign load_en    = (state_ff == nlk_pkg::NLK_ST_LOAD);
	assign prog_go    = prog_req.valid && !load_en;

	// 01 is not a listed programmer code; it falls to the closed side
	always_comb begin
		prog_refuse = 1'b0;
		unique case (prog_req.op)
			nlk_pkg::NLK_OP_WRITE_MEM,
			nlk_pkg::NLK_OP_WRITE_FUSE:
				prog_refuse = code[nlk_pkg::PROG_FIELD]
					!= nlk_pkg::PROG_UNLOCKED_CODE;
			nlk_pkg::NLK_OP_READ_MEM,
			nlk_pkg::NLK_OP_READ_FUSE,
			nlk_pkg::NLK_OP_READ_LOCK,
			nlk_pkg::NLK_OP_WRITE_LOCK:
				prog_refuse = !code[nlk_pkg::PROG_FIELD][1];
			nlk_pkg::NLK_OP_CHIP_ERASE:
				prog_refuse = 1'b0;
			nlk_pkg::NLK_OP_IDLE:
				prog_refuse = 1'b0;
		endcase
	end

	assign prog_wr_lock = prog_go && !prog_refuse
		&& prog_req.op == nlk_pkg::NLK_OP_WRITE_LOCK;
	assign erase_go = !load_en && (cpu_erase || (prog_go
		&& prog_req.op == nlk_pkg::NLK_OP_CHIP_ERASE));

	// simultaneous writers merge bitwise: a field takes the AND of the two codes
	genvar gi;
	generate
		for (gi = 0; gi < nlk_pkg::NUM_FIELDS; gi++) begin : g_field
			logic cpu_wr;
			logic [1:0] cpu_code;
			logic [1:0] prog_code;
			// software cannot reach the programmer field
			assign cpu_wr    = wb_wr_lock && (gi != nlk_pkg::PROG_FIELD);
			assign cpu_code  = cpu_wr ? wb_dat_i[2*gi +: 2]
				: nlk_pkg::UNLOCKED_CODE;
			assign prog_code = prog_wr_lock ? prog_req.wdata[2*gi +: 2]
				: nlk_pkg::UNLOCKED_CODE;
			assign fld_wr_en[gi]   = cpu_wr || prog_wr_lock;
			assign fld_wr_code[gi] = cpu_code & prog_code;

			nlk_lock_field u_field (
				.clk_sys   (clk_sys),
				.reset     (reset),
				.load_en   (load_en),
				.load_code (nvm_lock_image[2*gi +: 2]),
				.erase     (erase_go),
				.wr_en     (fld_wr_en[gi]),
				.wr_code   (fld_wr_code[gi]),
				.code_ff   (code[gi]),
				.reject    (fld_reject[gi])
			);
		end
	endgenerate

	// image is taken by a clocked step after release, never under reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_ff <= nlk_pkg::NLK_ST_LOAD;
		end else begin
			unique case (state_ff)
				nlk_pkg::NLK_ST_LOAD: state_ff <= nlk_pkg::NLK_ST_RUN;
				nlk_pkg::NLK_ST_RUN:  state_ff <= nlk_pkg::NLK_ST_RUN;
			endcase
		end
	end

	always_comb begin
		unique case (cpu_req.target)
			nlk_pkg::NLK_SEC_APP:   tgt_code = code[nlk_pkg::APP_FIELD];
			nlk_pkg::NLK_SEC_TABLE: tgt_code = code[nlk_pkg::TABLE_FIELD];
			nlk_pkg::NLK_SEC_BOOT:  tgt_code = code[nlk_pkg::BOOT_FIELD];
			nlk_pkg::NLK_SEC_NONE:  tgt_code = nlk_pkg::UNLOCKED_CODE;
		endcase
	end

	// boot is read-guarded against app code; app and table against boot
	always_comb begin
		if (cpu_req.is_store) begin
			cpu_block = write_locked(tgt_code);
		end else if (cpu_req.target == nlk_pkg::NLK_SEC_BOOT) begin
			cpu_block = read_locked(tgt_code) && !cpu_in_boot;
		end else begin
			cpu_block = read_locked(tgt_code) && cpu_in_boot;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cpu_rsp_ff <= '0;
		end else begin
			cpu_rsp_ff.done  <= cpu_req.valid;
			cpu_rsp_ff.allow <= cpu_req.valid && !cpu_block;
		end
	end

	assign app_rd_any = read_locked(code[nlk_pkg::APP_FIELD])
		|| read_locked(code[nlk_pkg::TABLE_FIELD]);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_off_ff <= 1'b0;
		end else begin
			irq_off_ff <= vec_boot_ff
				? (app_rd_any && !cpu_in_boot)
				: (read_locked(code[nlk_pkg::BOOT_FIELD]) && cpu_in_boot);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prog_rsp_ff <= '0;
		end else begin
			prog_rsp_ff.done  <= prog_go;
			prog_rsp_ff.grant <= prog_go && !prog_refuse;
			prog_rsp_ff.rdata <= (prog_go && !prog_refuse
				&& prog_req.op == nlk_pkg::NLK_OP_READ_LOCK)
				? lock_byte : 8'h00;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			vec_boot_ff <= 1'b0;
		end else if (wb_wr && hit(wb_adr_i, nlk_pkg::ADDR_CTRL)) begin
			vec_boot_ff <= wb_dat_i[nlk_pkg::CTRL_VEC_BOOT_BIT];
		end
	end

	// hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stat_ff <= nlk_pkg::STAT_RESET;
		end else begin
			logic [4:0] set;
			logic [4:0] clr;
			set = '0;
			set[nlk_pkg::STAT_STORE_BLOCKED] =
				cpu_req.valid && cpu_req.is_store && cpu_block;
			set[nlk_pkg::STAT_LOAD_BLOCKED] =
				cpu_req.valid && !cpu_req.is_store && cpu_block;
			set[nlk_pkg::STAT_PROG_REFUSED] = prog_go && prog_refuse;
			set[nlk_pkg::STAT_WR_REJECTED] =
				!erase_go && !load_en && (|fld_reject);
			set[nlk_pkg::STAT_ERASE_DONE] = erase_go;
			clr = (wb_wr && hit(wb_adr_i, nlk_pkg::ADDR_STAT))
				? wb_dat_i[4:0] : 5'h00;
			stat_ff <= (stat_ff & ~clr) | set;
		end
	end

	// one wait state: ack rises the edge after the request is seen
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_req;
			if (wb_req && !wb_we_i) begin
				if (hit(wb_adr_i, nlk_pkg::ADDR_LOCK)) begin
					dat_ff <= {24'h00_0000, lock_byte};
				end else if (hit(wb_adr_i, nlk_pkg::ADDR_CTRL)) begin
					dat_ff <= {30'h0000_0000, vec_boot_ff, 1'b0};
				end else if (hit(wb_adr_i, nlk_pkg::ADDR_STAT)) begin
					dat_ff <= {27'h000_0000, stat_ff};
				end else begin
					dat_ff <= 32'h0000_0000;
				end
			end else begin
				dat_ff <= 32'h0000_0000;
			end
		end
	end

	assign wb_ack_o    = ack_ff;
	assign wb_dat_o    = dat_ff;
	assign cpu_rsp     = cpu_rsp_ff;
	assign prog_rsp    = prog_rsp_ff;
	assign irq_disable = irq_off_ff;
	assign lock_byte   = {code[3], code[2], code[1], code[0]};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_cpu_store(logic [1:0] sec);
		cpu_req.valid && cpu_req.is_store && cpu_req.target == sec;
	endsequence

	sequence s_denied;
		cpu_rsp.done && !cpu_rsp.allow;
	endsequence

	sequence s_settled;
		state_ff == nlk_pkg::NLK_ST_RUN && !erase_go;
	endsequence

	AST_APP_OPEN: assert property (
		cpu_req.valid && cpu_req.target == nlk_pkg::NLK_SEC_APP
		&& code[nlk_pkg::APP_FIELD] == 2'h3 |=> cpu_rsp.allow)
		else $error("open app section access denied");

	AST_APP_STORE_BLOCK: assert property (
		s_cpu_store(nlk_pkg::NLK_SEC_APP)
		and code[nlk_pkg::APP_FIELD] == 2'h2 |=> s_denied)
		else $error("store into write-locked app section allowed");

	AST_APP_BOOT_LOAD: assert property (
		cpu_req.valid && !cpu_req.is_store && cpu_in_boot
		&& cpu_req.target == nlk_pkg::NLK_SEC_APP
		&& code[nlk_pkg::APP_FIELD] == 2'h1 |=> s_denied)
		else $error("boot load of read-locked app section allowed");

	AST_APP_FULL: assert property (
		cpu_req.valid && cpu_req.target == nlk_pkg::NLK_SEC_APP
		&& (cpu_req.is_store || cpu_in_boot)
		&& code[nlk_pkg::APP_FIELD] == 2'h0 |=> s_denied)
		else $error("fully locked app section access allowed");

	AST_TABLE_STORE: assert property (
		s_cpu_store(nlk_pkg::NLK_SEC_TABLE)
		and !code[nlk_pkg::TABLE_FIELD][0] |=> s_denied)
		else $error("store into write-locked table allowed");

	AST_IRQ_OFF: assert property (
		vec_boot_ff && !cpu_in_boot && app_rd_any |=> irq_disable)
		else $error("interrupts left on under read lock");

	AST_NO_RELAX: assert property (
		s_settled |=> (lock_byte & ~$past(lock_byte)) == 8'h00)
		else $error("lock field relaxed without chip erase");

	AST_ERASE_OPEN: assert property (
		erase_go |=> lock_byte == nlk_pkg::LOCK_RESET
		&& stat_ff[nlk_pkg::STAT_ERASE_DONE])
		else $error("chip erase did not open every field");

	AST_PROG_FIELD_CPU: assert property (
		s_settled and (!prog_wr_lock)
		|=> $stable(code[nlk_pkg::PROG_FIELD]))
		else $error("programmer field changed by software");

	AST_PROG_OPEN: assert property (
		prog_go && code[nlk_pkg::PROG_FIELD] == 2'h3
		|=> prog_rsp.done && prog_rsp.grant)
		else $error("unlocked programmer access refused");

	AST_PROG_WRITE_PROTECT_CODE: assert property (
		prog_go && code[nlk_pkg::PROG_FIELD] == 2'h2
		&& (prog_req.op == nlk_pkg::NLK_OP_WRITE_MEM
		|| prog_req.op == nlk_pkg::NLK_OP_WRITE_FUSE)
		|=> prog_rsp.done && !prog_rsp.grant)
		else $error("programmer write allowed under write lock");

	AST_PROG_FULL: assert property (
		prog_go && !code[nlk_pkg::PROG_FIELD][1]
		&& prog_req.op != nlk_pkg::NLK_OP_CHIP_ERASE
		&& prog_req.op != nlk_pkg::NLK_OP_IDLE
		|=> !prog_rsp.grant && prog_rsp.rdata == 8'h00)
		else $error("programmer access allowed under full lock");

	AST_WB_ACK: assert property (
		wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a one-cycle pulse");

endmodule : nlk_lock_enforce

`default_nettype wire

/* verification/nlk_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

module nlk_far_model (
	input  wire logic                   clk_sys,
	input  wire nlk_pkg::nlk_cpu_rsp_t  cpu_rsp,
	input  wire nlk_pkg::nlk_prog_rsp_t prog_rsp,
	output var nlk_pkg::nlk_cpu_req_t   cpu_req,
	output var logic                    cpu_in_boot,
	output var nlk_pkg::nlk_prog_req_t  prog_req
);
	// idle fields carry the inverse of the last request, never a stale copy
	initial begin
		cpu_req = '0;
		cpu_in_boot = 1'h0;
		prog_req = '0;
	end

	task automatic cpu_acc(input logic st, input logic [1:0] tg,
		input logic bt, output logic allow);
		int i;
		@(posedge clk_sys);
		cpu_in_boot <= bt;
		cpu_req <= {1'h1, st, tg};
		@(posedge clk_sys);
		cpu_req <= {1'h0, ~st, ~tg};
		allow = 1'hx;
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			if (cpu_rsp.done === 1'h1) begin
				allow = cpu_rsp.allow;
				break;
			end
		end
	endtask : cpu_acc

	task automatic prog_acc(input logic [2:0] op, input logic [7:0] wd,
		output logic grant, output logic [7:0] rd);
		int i;
		@(posedge clk_sys);
		prog_req <= {1'h1, op, wd};
		@(posedge clk_sys);
		prog_req <= {1'h0, ~op, ~wd};
		grant = 1'hx;
		rd = 8'hxx;
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			if (prog_rsp.done === 1'h1) begin
				grant = prog_rsp.grant;
				rd = prog_rsp.rdata;
				break;
			end
		end
	endtask : prog_acc
endmodule : nlk_far_model

`default_nettype wire

/* verification/test_nvm_lock_bit_enforcement.sv */
`timescale 1ns/1ps
`default_nettype none

`define NLK_CHK(got, exp, what) \
	begin cmp_count++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED t=%0t %s", $time, what); end end

module test_nvm_lock_bit_enforcement;
	logic                   clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]             nvm_lock_image, wb_adr_i, lock_byte, exp_lock, pr;
	logic [3:0]             wb_sel_i;
	logic [7:0]             ep;
	logic [31:0]            wb_dat_i, wb_dat_o, rd, r;
	logic                   wb_ack_o, cpu_in_boot, irq_disable, ok, g, ge, vb;
	nlk_pkg::nlk_cpu_req_t  cpu_req;
	nlk_pkg::nlk_cpu_rsp_t  cpu_rsp;
	nlk_pkg::nlk_prog_req_t prog_req;
	nlk_pkg::nlk_prog_rsp_t prog_rsp;
	int                     fails, cmp_count, c, v, k, n;
	integer                 seed = 22641;

	nlk_lock_enforce uut (.clk_sys(clk_sys), .reset(reset),
		.nvm_lock_image(nvm_lock_image), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cpu_req(cpu_req), .cpu_in_boot(cpu_in_boot),
		.cpu_rsp(cpu_rsp), .irq_disable(irq_disable), .prog_req(prog_req),
		.prog_rsp(prog_rsp), .lock_byte(lock_byte));

	nlk_far_model far (.clk_sys(clk_sys), .cpu_rsp(cpu_rsp),
		.prog_rsp(prog_rsp), .cpu_req(cpu_req), .cpu_in_boot(cpu_in_boot),
		.prog_req(prog_req));

	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end

	// a field only takes codes that clear bits of the current code
	function automatic logic [7:0] strict(logic [7:0] cur, logic [7:0] nw,
		logic [3:0] fm);
		logic [7:0] res;
		int i;
		res = cur;
		for (i = 0; i < 4; i++)
			if (fm[i] && ((nw[2*i+:2] & ~cur[2*i+:2]) == 2'h0))
				res[2*i+:2] = nw[2*i+:2];
		return res;
	endfunction : strict

	function automatic logic exp_cpu(logic [7:0] lk, logic st, logic [1:0] tg,
		logic bt);
		logic [1:0] cd;
		cd = (tg == 2'h0) ? lk[5:4] : (tg == 2'h1) ? lk[3:2] : lk[7:6];
		if (tg == 2'h3) return 1'h1;
		if (st) return cd[0];
		return (tg == 2'h2) ? (bt | cd[1]) : (~bt | cd[1]);
	endfunction : exp_cpu

	function automatic logic exp_prog(logic [7:0] lk, logic [2:0] op);
		if (op == 3'h6 || lk[1:0] == 2'h3) return 1'h1;
		if (lk[1:0] == 2'h2) return !(op == 3'h1 || op == 3'h3);
		return 1'h0;
	endfunction : exp_prog

	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, input logic [3:0] sel, output logic [31:0] rdat);
		int i;
		@(posedge clk_sys);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		rdat = 32'hxxxxxxxx;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			if (wb_ack_o === 1'h1) begin
				rdat = wb_dat_o;
				break;
			end
		end
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		// a write lands on the ack edge; let it settle before callers look
		@(posedge clk_sys);
		`NLK_CHK(i < 8, 1'h1, "bus ack missing")
	endtask : wb

	task print_verdict;
		$display("mismatches %0d of %0d compares", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		print_verdict;
	end

	initial begin
		reset = 1'h1;
		nvm_lock_image = 8'hff;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		repeat (20) @(posedge clk_sys);
		reset <= 1'h0;
		repeat (3) @(posedge clk_sys);
		`NLK_CHK(lock_byte, 8'hff, "load")
		wb(1'h0, nlk_pkg::ADDR_CTRL, 32'h0, 4'h1, rd);
		`NLK_CHK(rd, 32'h0, "ctrl reset")
		wb(1'h0, nlk_pkg::ADDR_STAT, 32'h0, 4'h1, rd);
		`NLK_CHK(rd, 32'h0, "stat reset")
		wb(1'h1, 8'h0c, 32'h0, 4'h1, rd);
		wb(1'h0, 8'h0c, 32'h0, 4'h1, rd);
		`NLK_CHK({rd, lock_byte}, {32'h0, 8'hff}, "unmapped")
		// every code on the three section fields, vectors in both places
		for (c = 0; c < 4; c++) for (v = 0; v < 2; v++) begin
			vb = v[0];
			wb(1'h1, nlk_pkg::ADDR_CTRL, {30'h0, vb, 1'h1}, 4'h1, rd);
			`NLK_CHK(lock_byte, 8'hff, "sw erase")
			exp_lock = {c[1:0], c[1:0], c[1:0], 2'h3};
			wb(1'h1, nlk_pkg::ADDR_LOCK, {24'h0, exp_lock}, 4'h1, rd);
			`NLK_CHK(lock_byte, exp_lock, "field write")
			for (k = 0; k < 16; k++) begin
				far.cpu_acc(k[0], k[2:1], k[3], ok);
				ge = exp_cpu(exp_lock, k[0], k[2:1], k[3]);
				`NLK_CHK(ok, ge, "cpu")
				ge = (vb ? ~k[3] : k[3]) & ~c[1];
				`NLK_CHK(irq_disable, ge, "irq")
			end
		end
		// every programming code against every programmer operation but chip erase and idle
		for (c = 0; c < 4; c++) begin
			far.prog_acc(3'h6, 8'h00, g, pr);
			`NLK_CHK({g, lock_byte}, {1'h1, 8'hff}, "erase")
			exp_lock = {6'h3f, c[1:0]};
			far.prog_acc(3'h5, exp_lock, g, pr);
			`NLK_CHK(lock_byte, exp_lock, "prog field")
			for (k = 0; k < 6; k++) begin
				far.prog_acc(k[2:0], 8'hff, g, pr);
				ge = exp_prog(exp_lock, k[2:0]);
				ep = (ge && k == 4) ? exp_lock : 8'h0;
				`NLK_CHK(g, ge, "grant")
				`NLK_CHK(pr, ep, "rdata")
			end
			`NLK_CHK(lock_byte, exp_lock, "no relax")
		end
		// status flags: clear them all, then let one erase raise its flag
		wb(1'h1, nlk_pkg::ADDR_STAT, 32'h1f, 4'h1, rd);
		wb(1'h0, nlk_pkg::ADDR_STAT, 32'h0, 4'h1, rd);
		`NLK_CHK(rd, 32'h0, "stat clear")
		far.prog_acc(3'h6, 8'h00, g, pr);
		wb(1'h0, nlk_pkg::ADDR_STAT, 32'h0, 4'h1, rd);
		`NLK_CHK(rd, 32'h1 << nlk_pkg::STAT_ERASE_DONE, "stat erase")
		reset <= 1'h1;
		r = $random(seed);
		repeat (2) @(posedge clk_sys);
		nvm_lock_image <= r[7:0];
		reset <= 1'h0;
		repeat (3) @(posedge clk_sys);
		exp_lock = r[7:0];
		`NLK_CHK(lock_byte, exp_lock, "reload")
		for (n = 0; n < 300; n++) begin
			r = $random(seed);
			case (r[1:0])
				2'h0: begin
					wb(1'h1, nlk_pkg::ADDR_LOCK, {24'h0, r[15:8]}, {3'h0, r[2]},
						rd);
					if (r[2]) exp_lock = strict(exp_lock, r[15:8], 4'he);
				end
				2'h1: begin
					far.cpu_acc(r[4], r[6:5], r[7], ok);
					ge = exp_cpu(exp_lock, r[4], r[6:5], r[7]);
					`NLK_CHK(ok, ge, "cpu")
				end
				2'h2: begin
					if (r[6:4] == 3'h7) r[6:4] = 3'h4;
					far.prog_acc(r[6:4], r[15:8], g, pr);
					ge = exp_prog(exp_lock, r[6:4]);
					ep = (ge && r[6:4] == 3'h4) ? exp_lock : 8'h0;
					`NLK_CHK(g, ge, "grant")
					`NLK_CHK(pr, ep, "rdata")
					if (ge && r[6:4] == 3'h6) exp_lock = 8'hff;
					if (ge && r[6:4] == 3'h5)
						exp_lock = strict(exp_lock, r[15:8], 4'hf);
				end
				default: begin
					wb(1'h0, nlk_pkg::ADDR_LOCK, 32'h0, 4'h1, rd);
					`NLK_CHK(rd, {24'h0, exp_lock}, "lock read")
				end
			endcase
			`NLK_CHK(lock_byte, exp_lock, "lock byte")
		end
		print_verdict;
	end
endmodule : test_nvm_lock_bit_enforcement

`default_nettype wire
